// [bench/rbs_ctrl_model.sv]
module rbs_ctrl_model (
  input  wire logic clk_i, miso_i,
  output logic [5:0] addr_o = 6'h00,
  output logic sclk_o = 1'b0, mosi_o = 1'b0
);
  timeunit 1ns; timeprecision 1ns;
  logic [11:0] rd;
  // Mode 0; released address and MOSI lines show the inverse, never the last level; SCLK returns low
  task automatic xfer(logic [5:0] a, logic [11:0] w, int n);
    addr_o = a;
    repeat (4) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      #1 mosi_o = w[i];
      repeat (5) @(posedge clk_i);
      #1 rd = {rd[10:0], miso_i};
      sclk_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    #1 mosi_o = ~mosi_o;
    addr_o = ~a;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
endmodule

// [bench/rbs_decode_assertions.sv]
module rbs_decode_assertions (
  input wire logic clk_i, rst_n_i, spi_miso_o, steer_update_o,
  input wire logic steer_sel_o, diag_sel_o,
  input wire logic [3:0] card_addr_i,
  input wire logic [5:0] addr_i,
  input wire logic [11:0] steer_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_steer_dec: assert property (steer_sel_o |->
    $past(addr_i, 3) == {card_addr_i, 2'h0}) else $error("steer sel");
  a_diag_dec: assert property (diag_sel_o |->
    $past(addr_i, 3) == {card_addr_i, 2'h1}) else $error("diag sel");
  a_level_hold: assert property (!$stable(steer_level_o) |->
    steer_update_o) else $error("level moved");
  a_update_src: assert property (steer_update_o |-> !steer_sel_o &&
    ($past(steer_sel_o, 2) || $past(steer_sel_o, 3))) else $error("upd");
  a_miso_idle: assert property (!diag_sel_o && !$past(diag_sel_o)
    |-> !spi_miso_o) else $error("miso");
  a_sel_onehot: assert property (!(steer_sel_o && diag_sel_o))
    else $error("two selects");
  a_upd_pulse: assert property (steer_update_o |=> !steer_update_o)
    else $error("update too long");
endmodule
bind rbs_decode rbs_decode_assertions u_chk (.*);

// [bench/rbs_decode_test.sv]
module rbs_decode_test;
  timeunit 1ns; timeprecision 1ns;
  localparam logic [3:0] CARD = 4'h5;
  logic clk_i = 1'b0, rst_n_i = 1'b0, sclk, mosi, miso, upd;
  logic [1:0] ch = 2'h0;
  logic [5:0] addr;
  logic [11:0] ref_s = 12'h0, sup_s = 12'h0, w, lvl, q[$];
  int seed = 32'hd24b, error_cnt = 0, total_checks = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  rbs_decode dut (.clk_i, .rst_n_i, .card_addr_i(CARD), .addr_i(addr),
    .spi_sclk_i(sclk), .spi_mosi_i(mosi), .diag_ch_i(ch),
    .ref_sample_i(ref_s), .supply_sample_i(sup_s), .spi_miso_o(miso),
    .steer_sel_o(), .diag_sel_o(), .steer_level_o(lvl), .steer_update_o(upd));
  rbs_ctrl_model m (.clk_i, .miso_i(miso), .addr_o(addr), .sclk_o(sclk),
    .mosi_o(mosi));
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    total_checks++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("Error %0t: got %h want %h", $time, got, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) error_cnt++;
    if (cyc == 4000) finish_test;
  end
  // Look mid-cycle so the one-cycle pulse is seen settled, once
  always @(negedge clk_i) if (upd) chk(lvl, q.pop_front());
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk(lvl, 12'h800);
    for (int k = 0; k < 3; k++) begin
      w = 12'($random(seed));
      q.push_back(w);
      m.xfer({CARD, 2'h0}, w, 12);
    end
    m.xfer({CARD, 2'h0}, ~w, 11);
    $display("steer done");
    ref_s = 12'($random(seed));
    sup_s = 12'($random(seed));
    for (int k = 0; k < 4; k++) begin
      ch = k[1:0];
      m.xfer({CARD, 2'h1}, w, 12);
      chk(m.rd, k == 0 ? ref_s : k == 1 ? sup_s : w);
    end
    for (int k = 0; k < 64; k++) m.xfer(k[5:0], w, 0);
    chk(lvl, w);
    $display("read and decode done");
    finish_test;
  end
endmodule

// [rtl/rbs_decode.sv]
// What this block does
// [R1] Match A5..A2 to card address first
// [R2] Decode A1..A0 into steering or diagnostic select
// [R3] Shift in 12-bit steering word, hold level
// [R4] Controller updates steering only at setup
// [R5] Digitised diagnostic values shift out over SPI
// [R6] Channels: reference, supply and steering samples
// [R7] One select at most, none without match
module rbs_decode (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  card_addr_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  input  wire logic [1:0]  diag_ch_i,
  input  wire logic [11:0] ref_sample_i,
  input  wire logic [11:0] supply_sample_i,
  output logic             spi_miso_o,
  output logic             steer_sel_o,
  output logic             diag_sel_o,
  output logic [11:0]      steer_level_o,
  output logic             steer_update_o
);
  logic [5:0]  addr_s;
  logic        sclk_s;
  logic        mosi_s;
  logic        sclk_d1_q;
  logic [11:0] shift_q;
  logic [4:0]  cnt_q;
  logic [11:0] diag_q;
  logic        sel_prev_q;
  logic        diag_prev_q;

  rbs_sync #(.W(8)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({addr_i, spi_sclk_i, spi_mosi_i}),
    .q_o     ({addr_s, sclk_s, mosi_s})
  );

  wire board_hit  = (addr_s[rbs_pkg::BOARD_MSB:rbs_pkg::BOARD_LSB]
                     == card_addr_i); // [R1]
  wire steer_hit  = board_hit
                    && (addr_s[1:0] == rbs_pkg::SEL_STEER); // [R2] [R7]
  wire diag_hit   = board_hit
                    && (addr_s[1:0] == rbs_pkg::SEL_DIAG); // [R2] [R7]
  wire sclk_rise  = sclk_s && !sclk_d1_q;
  wire sclk_fall  = !sclk_s && sclk_d1_q;
  // Diagnostic start has its own history so a read never restarts
  wire sel_start  = diag_sel_o && !diag_prev_q; // [R5]
  // Word is applied only when at least twelve bits arrived, so a
  // stray deselect mid-word cannot pull the oscillator off frequency
  wire steer_done = sel_prev_q && !steer_sel_o
                    && (cnt_q == 5'(rbs_pkg::STEER_W)); // [R3]
  wire [11:0] diag_pick = (diag_ch_i == rbs_pkg::CH_REF) ? ref_sample_i :
                          (diag_ch_i == rbs_pkg::CH_SUPPLY) ?
                          supply_sample_i : steer_level_o; // [R6]

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      steer_sel_o <= 1'b0;
      diag_sel_o  <= 1'b0;
      sclk_d1_q   <= 1'b0;
      sel_prev_q  <= 1'b0;
      diag_prev_q <= 1'b0;
    end else begin
      steer_sel_o <= steer_hit; // [R7]
      diag_sel_o  <= diag_hit; // [R7]
      sclk_d1_q   <= sclk_s;
      sel_prev_q  <= steer_sel_o;
      diag_prev_q <= diag_sel_o;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= rbs_pkg::STEER_RST;
      cnt_q   <= rbs_pkg::CNT_RST;
    end else if (!steer_sel_o) begin
      cnt_q   <= rbs_pkg::CNT_RST;
    end else if (sclk_rise && cnt_q < 5'(rbs_pkg::STEER_W)) begin
      shift_q <= {shift_q[10:0], mosi_s}; // [R3]
      cnt_q   <= cnt_q + 5'h01;
    end
  end

  // Held level changes only on a complete word; updates are rare
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      steer_level_o  <= rbs_pkg::STEER_RST;
      steer_update_o <= 1'b0;
    end else begin
      steer_update_o <= steer_done; // [R4]
      if (steer_done) begin
        steer_level_o <= shift_q; // [R3]
      end
    end
  end

  // Sample is latched at select so it stays stable while shifting out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_q     <= rbs_pkg::DIAG_RST;
      spi_miso_o <= 1'b0;
    end else if (!diag_sel_o) begin
      diag_q     <= diag_pick; // [R5]
      spi_miso_o <= 1'b0;
    end else if (sel_start || sclk_fall) begin
      spi_miso_o <= diag_q[11]; // [R5]
      diag_q     <= {diag_q[10:0], 1'b0};
    end
  end
endmodule

// [rtl/rbs_pkg.sv]
package rbs_pkg;
  // Card address on A5..A2; arbitrary default, strapped per slot
  localparam logic [3:0]  CARD_ADDR_RST  = 4'hA;
  localparam int          ADDR_W         = 6;
  localparam int          BOARD_LSB      = 2;
  localparam int          BOARD_MSB      = 5;
  localparam logic [1:0]  SEL_STEER      = 2'h0;
  localparam logic [1:0]  SEL_DIAG       = 2'h1;
  localparam int          STEER_W        = 12;
  localparam logic [11:0] STEER_RST      = 12'h800;
  localparam int          DIAG_W         = 12;
  localparam int          CH_W           = 2;
  localparam logic [1:0]  CH_REF         = 2'h0;
  localparam logic [1:0]  CH_SUPPLY      = 2'h1;
  localparam logic [1:0]  CH_STEER       = 2'h2;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [11:0] DIAG_RST       = 12'h000;
  localparam logic [4:0]  CNT_RST        = 5'h00;
endpackage

// [rtl/rbs_sync.sv]
module rbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
